// ### mbs_slave.sv
/*
  Slave end: collects request frames, checks and executes them on a local register
  file, and answers after the response delay; sleeps its line circuit in low power.
  Assumes the master keeps to the frame rules and retries unanswered requests.
*/
`timescale 1ns/1ps
module mbs_slave #(
  parameter int unsigned RESP_CYCLES = mbs_pkg::RESP_CYC,
  parameter int unsigned NREG        = 256,
  parameter logic [7:0]  SLAVE_ADDR  = 8'h01
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  mbs_link_if.slave                    link,
  input  wire logic                    lowPower,
  input  wire logic [$clog2(NREG)-1:0] appAddr,
  output wire logic [15:0]             appData,
  output wire logic                    wrPulse
);
  import mbs_pkg::*;

  // ----------------------------------------------------------------
  // types and storage
  // ----------------------------------------------------------------
  localparam int unsigned AW = $clog2(NREG);
  localparam int unsigned DW = $clog2(RESP_CYCLES + 1);

  typedef enum logic [4:0] {
    S_RX   = 5'b00001,
    S_CHK  = 5'b00010,
    S_EXEC = 5'b00100,
    S_WAIT = 5'b01000,
    S_TX   = 5'b10000
  } mbs_sst_t;

  typedef struct packed {
    mbs_sst_t    st;
    logic        lp1;
    logic        lp2;
    logic        awake;
    logic [7:0]  rxLen;
    logic        ovf;
    logic [7:0]  idx;
    logic [7:0]  txLen;
    logic [7:0]  exc;
    logic        bcast;
    logic [DW-1:0] dly;
    logic [15:0] diag;
    logic        rspValid;
    logic [7:0]  rspData;
    logic        rspLast;
    logic [15:0] appData;
    logic        wrPulse;
  } mbs_sstate_t;

  mbs_sstate_t q;
  mbs_sstate_t d;
  logic [7:0]  rxBuf [BUF_BYTES];
  logic [15:0] regs  [NREG];
  logic        rxWe;
  logic        regWe;
  logic [AW-1:0] regWa;
  logic [15:0] regWd;
  logic [7:0]  fc;
  logic [15:0] start;
  logic [15:0] qty;
  logic [15:0] wStart;
  logic [15:0] wQty;
  logic [15:0] wrStart;
  logic [15:0] wrCnt;
  logic [7:0]  wrBase;
  logic [7:0]  rdOff;
  logic [15:0] rdWord;
  logic [7:0]  txByte;
  logic        asleep;
  logic        isRead;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] word(input logic [7:0] i);
    word = {rxBuf[i], rxBuf[8'(i + 8'h01)]};
  endfunction

  function automatic logic inRange(input logic [15:0] s, input logic [15:0] n);
    inRange = ({1'b0, s} + {1'b0, n}) <= 17'(NREG);
  endfunction

  function automatic logic cntOk(input logic [15:0] n, input int unsigned lim);
    cntOk = (n != 16'h0000) && (32'(n) <= lim);
  endfunction

  // byte count field and frame length must both match the register count
  function automatic logic bodyOk(input logic [15:0] n, input logic [7:0] bcOfs,
                                  input logic [7:0] len);
    bodyOk = (rxBuf[bcOfs] == {n[6:0], 1'b0}) &&
             ({1'b0, len} == 9'(bcOfs) + 9'h001 + {n[7:0], 1'b0});
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign fc     = rxBuf[OFS_FUNC];
  assign start  = word(OFS_START);
  assign qty    = word(OFS_QTY);
  assign wStart = word(OFS_WSTART);
  assign wQty   = word(OFS_WQTY);
  assign asleep = q.lp2 && !q.awake;
  assign isRead = (fc == FC_RD_HOLD) || (fc == FC_RD_INPUT) || (fc == FC_RD_WR);

  // write span per function; zero count means nothing to store
  always_comb begin
    wrStart = start;
    wrCnt   = qty;
    wrBase  = OFS_BC16 + 8'h01;
    case (fc)
      FC_WR_ONE: begin
        wrCnt  = 16'h0001;
        wrBase = OFS_QTY;
      end
      FC_WR_MULTI: begin
        wrCnt = qty;
      end
      FC_RD_WR: begin
        wrStart = wStart;
        wrCnt   = wQty;
        wrBase  = OFS_BC23 + 8'h01;
      end
      default: begin
        wrCnt = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // response byte generator, indexed by q.idx
  // ----------------------------------------------------------------
  always_comb begin
    rdOff  = q.idx - HDR_LEN;
    rdWord = regs[AW'(start + {9'h000, rdOff[7:1]})];
    txByte = rxBuf[q.idx];                          // echo for 06, 16 and loopback
    if (q.exc != 8'h00) begin
      if (q.idx == OFS_FUNC) begin
        txByte = fc | EXC_FLAG;
      end else if (q.idx == OFS_START) begin
        txByte = q.exc;
      end
    end else if (isRead) begin
      if (q.idx == OFS_START) begin
        txByte = 8'(q.txLen - HDR_LEN);
      end else if (q.idx > OFS_START) begin
        txByte = rdOff[0] ? rdWord[7:0] : rdWord[15:8];
      end
    end else if (fc == FC_DIAG && start == DIAG_REG) begin
      if (q.idx == OFS_QTY) begin
        txByte = q.diag[15:8];
      end else if (q.idx == OFS_QTY + 8'h01) begin
        txByte = q.diag[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.lp1      = lowPower;
    d.lp2      = q.lp1;
    d.rspValid = 1'b0;
    d.rspLast  = 1'b0;
    d.wrPulse  = 1'b0;
    d.appData  = regs[appAddr];
    rxWe       = 1'b0;
    regWe      = 1'b0;
    regWa      = AW'(wrStart + {8'h00, q.idx});
    regWd      = word(8'(wrBase + {q.idx, 1'b0}));
    case (q.st)
      S_RX: begin
        if (link.reqValid) begin
          if (!asleep) begin
            rxWe = (q.rxLen != 8'hff);
            if (q.rxLen == 8'hff) begin
              d.ovf = 1'b1;
            end else begin
              d.rxLen = q.rxLen + 8'h01;
            end
          end
          if (link.reqLast) begin
            if (asleep) begin
              d.awake = 1'b1;
              d.rxLen = 8'h00;
            end else begin
              d.st  = S_CHK;
              d.dly = '0;
            end
          end
        end
      end
      S_CHK: begin
        d.idx   = 8'h00;
        d.exc   = 8'h00;
        d.txLen = MIN_LEN;
        d.bcast = (rxBuf[0] == BCAST_ADDR);
        d.dly   = q.dly + 1'b1;
        case (fc)
          FC_RD_HOLD, FC_RD_INPUT: begin
            d.txLen = 8'(HDR_LEN + {qty[6:0], 1'b0});
            if (!cntOk(qty, RD_MAX)) begin
              d.exc = EXC_VALUE;
            end else if (!inRange(start, qty)) begin
              d.exc = EXC_ADDR;
            end
          end
          FC_WR_ONE: begin
            if (!inRange(start, 16'h0001)) begin
              d.exc = EXC_ADDR;
            end
          end
          FC_DIAG: begin
            if (start == DIAG_ECHO) begin
              d.txLen = q.rxLen;
            end else if (start != DIAG_REG) begin
              d.exc = EXC_FUNC;
            end
          end
          FC_WR_MULTI: begin
            if (!cntOk(qty, WR_MAX) || !bodyOk(qty, OFS_BC16, q.rxLen)) begin
              d.exc = EXC_VALUE;
            end else if (!inRange(start, qty)) begin
              d.exc = EXC_ADDR;
            end
          end
          FC_RD_WR: begin
            d.txLen = 8'(HDR_LEN + {qty[6:0], 1'b0});
            if (!cntOk(qty, RW_MAX) || !cntOk(wQty, RW_MAX) ||
                !bodyOk(wQty, OFS_BC23, q.rxLen)) begin
              d.exc = EXC_VALUE;
            end else if (!inRange(start, qty) || !inRange(wStart, wQty)) begin
              d.exc = EXC_ADDR;
            end
          end
          default: begin
            d.exc = EXC_FUNC;
          end
        endcase
        if (d.exc != 8'h00) begin
          d.txLen = HDR_LEN;
        end
        // frames for another slave, runts and overruns are dropped silently
        if (q.ovf || q.rxLen < MIN_LEN || (rxBuf[0] != SLAVE_ADDR && !d.bcast)) begin
          d.st    = S_RX;
          d.rxLen = 8'h00;
          d.ovf   = 1'b0;
        end else if (d.bcast && (d.exc != 8'h00 ||
                     !(fc == FC_WR_ONE || fc == FC_WR_MULTI || fc == FC_RD_WR))) begin
          d.st    = S_RX;
          d.rxLen = 8'h00;
        end else begin
          d.st = S_EXEC;
        end
      end
      S_EXEC: begin
        d.dly = q.dly + 1'b1;
        // one register per cycle; reads only happen later in S_TX
        if (q.exc == 8'h00 && {8'h00, q.idx} < wrCnt) begin
          regWe     = 1'b1;
          d.wrPulse = 1'b1;
          d.idx     = q.idx + 8'h01;
        end else begin
          d.idx = 8'h00;
          if (q.bcast) begin
            d.st    = S_RX;
            d.rxLen = 8'h00;
            d.awake = 1'b0;
          end else begin
            d.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        d.dly = q.dly + 1'b1;
        if (q.dly >= DW'(RESP_CYCLES - 1)) begin
          d.st = S_TX;
        end
      end
      S_TX: begin
        d.rspValid = 1'b1;
        d.rspData  = txByte;
        d.rspLast  = (q.idx == q.txLen - 8'h01);
        d.idx      = q.idx + 8'h01;
        if (d.rspLast) begin
          d.st    = S_RX;
          d.rxLen = 8'h00;
          d.awake = 1'b0;
          if (q.exc != 8'h00) begin
            d.diag = q.diag + 16'h0001;
          end
        end
      end
      default: begin
        d.st = S_RX;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= S_RX;
    end else begin
      q <= d;
    end
  end

  // storage is not reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (rxWe) begin
      rxBuf[q.rxLen] <= link.reqData;
    end
    if (regWe) begin
      regs[regWa] <= regWd;
    end
  end

  // awake only matters in low power, so the line is forced on otherwise
  assign link.lineOn   = !asleep;
  assign link.rspValid = q.rspValid;
  assign link.rspData  = q.rspData;
  assign link.rspLast  = q.rspLast;
  assign appData       = q.appData;
  assign wrPulse       = q.wrPulse;

endmodule

// ### mbs_pkg.sv
/*
  Shared constants for the request handler link: function codes, request field offsets,
  count limits, exception codes and timing counts.
  Assumes a single 50 MHz clock shared by both ends of the link.
*/
package mbs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RESP_TIME_US  = 3000;
  localparam int unsigned RESP_CYC      = (RESP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_TIME_US = 10000;
  localparam int unsigned RETRY_CYC     = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned MAX_TRIES     = 3;

  // ----------------------------------------------------------------
  // function codes, diagnostics sub-functions, exceptions
  // ----------------------------------------------------------------
  localparam logic [7:0]  FC_RD_HOLD  = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT = 8'h04;
  localparam logic [7:0]  FC_WR_ONE   = 8'h06;
  localparam logic [7:0]  FC_DIAG     = 8'h08;
  localparam logic [7:0]  FC_WR_MULTI = 8'h10;
  localparam logic [7:0]  FC_RD_WR    = 8'h17;
  localparam logic [15:0] DIAG_ECHO   = 16'h0000;
  localparam logic [15:0] DIAG_REG    = 16'h0002;
  localparam logic [7:0]  EXC_FLAG    = 8'h80;
  localparam logic [7:0]  EXC_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_ADDR    = 8'h02;
  localparam logic [7:0]  EXC_VALUE   = 8'h03;
  localparam logic [7:0]  BCAST_ADDR  = 8'h00;

  // ----------------------------------------------------------------
  // limits and request layout (byte offsets, no checksum on this link)
  // ----------------------------------------------------------------
  localparam int unsigned RD_MAX     = 125;
  localparam int unsigned WR_MAX     = 120;
  localparam int unsigned RW_MAX     = 118;
  localparam int unsigned BUF_BYTES  = 256;
  localparam logic [7:0]  MIN_LEN    = 8'h06;
  localparam logic [7:0]  OFS_FUNC   = 8'h01;
  localparam logic [7:0]  OFS_START  = 8'h02;
  localparam logic [7:0]  OFS_QTY    = 8'h04;
  localparam logic [7:0]  OFS_WSTART = 8'h06;
  localparam logic [7:0]  OFS_WQTY   = 8'h08;
  localparam logic [7:0]  OFS_BC16   = 8'h06;
  localparam logic [7:0]  OFS_BC23   = 8'h0a;
  localparam logic [7:0]  HDR_LEN    = 8'h03;

endpackage

// ### mbs_link_if.sv
/*
  Byte-stream link between the master end and the slave end.
  Assumes both ends run on the same clock; the testbench joins them.
*/
`timescale 1ns/1ps
interface mbs_link_if (
  input wire logic clk
);
  logic       reqValid;  // master to slave byte strobe
  logic [7:0] reqData;
  logic       reqLast;   // last byte of a request frame
  logic       rspValid;  // slave to master byte strobe
  logic [7:0] rspData;
  logic       rspLast;   // last byte of a response frame
  logic       lineOn;    // slave line circuit powered

  modport master (output reqValid, output reqData, output reqLast,
                  input rspValid, input rspData, input rspLast);
  modport slave  (input reqValid, input reqData, input reqLast,
                  output rspValid, output rspData, output rspLast, output lineOn);
endinterface

// ### mbs_master.sv
/*
  Master end: loads a request from the user side, sends it, retries it unchanged
  when no answer comes, and forwards the answer bytes to the user side.
  Assumes the slave answers well within the retry time.
*/
`timescale 1ns/1ps
module mbs_master #(
  parameter int unsigned RETRY_CYCLES = mbs_pkg::RETRY_CYC,
  parameter int unsigned TRIES        = mbs_pkg::MAX_TRIES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  mbs_link_if.master      link,
  input  wire logic       cmdValid,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdLast,
  output wire logic       cmdReady,
  output wire logic       ansValid,
  output wire logic [7:0] ansData,
  output wire logic       ansLast,
  output wire logic       done,
  output wire logic       noAnswer,
  output wire logic       refused
);
  import mbs_pkg::*;

  // ----------------------------------------------------------------
  // types and storage
  // ----------------------------------------------------------------
  localparam int unsigned TW = $clog2(RETRY_CYCLES + 1);

  typedef enum logic [2:0] {
    M_LOAD = 3'b001,
    M_SEND = 3'b010,
    M_WAIT = 3'b100
  } mbs_mst_t;

  typedef struct packed {
    mbs_mst_t    st;
    logic [7:0]  len;
    logic [7:0]  idx;
    logic [TW-1:0] tmr;
    logic [3:0]  tries;
    logic        heard;
    logic        reqValid;
    logic [7:0]  reqData;
    logic        reqLast;
    logic        ansValid;
    logic [7:0]  ansData;
    logic        ansLast;
    logic        done;
    logic        noAnswer;
    logic        refused;
  } mbs_mstate_t;

  mbs_mstate_t q;
  mbs_mstate_t d;
  logic [7:0]  reqBuf [BUF_BYTES];
  logic        bufWe;
  logic [7:0]  fcNow;
  logic        isBcast;

  // code byte may be arriving right now on a two-byte frame
  assign fcNow   = (q.len == OFS_FUNC) ? cmdData : reqBuf[OFS_FUNC];
  assign isBcast = (reqBuf[0] == BCAST_ADDR);

  // ----------------------------------------------------------------
  // control next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.reqValid = 1'b0;
    d.reqLast  = 1'b0;
    d.ansValid = 1'b0;
    d.ansLast  = 1'b0;
    d.done     = 1'b0;
    d.noAnswer = 1'b0;
    d.refused  = 1'b0;
    bufWe      = 1'b0;
    case (q.st)
      M_LOAD: begin
        if (cmdValid) begin
          bufWe = (q.len != 8'hff);
          if (q.len != 8'hff) begin
            d.len = q.len + 8'h01;
          end
          if (cmdLast) begin
            if (isBcast && !(fcNow == FC_WR_ONE || fcNow == FC_WR_MULTI ||
                             fcNow == FC_RD_WR)) begin
              d.refused = 1'b1;
              d.len     = 8'h00;
            end else begin
              d.st    = M_SEND;
              d.idx   = 8'h00;
              d.tries = 4'h0;
            end
          end
        end
      end
      M_SEND: begin
        d.reqValid = 1'b1;
        d.reqData  = reqBuf[q.idx];
        d.reqLast  = (q.idx == q.len - 8'h01);
        d.idx      = q.idx + 8'h01;
        if (d.reqLast) begin
          d.tries = q.tries + 4'h1;
          d.tmr   = '0;
          d.heard = 1'b0;
          if (isBcast) begin
            d.done = 1'b1;                          // nothing comes back
            d.st   = M_LOAD;
            d.len  = 8'h00;
          end else begin
            d.st = M_WAIT;
          end
        end
      end
      M_WAIT: begin
        d.tmr = q.tmr + 1'b1;
        if (link.rspValid) begin
          d.heard    = 1'b1;
          d.ansValid = 1'b1;
          d.ansData  = link.rspData;
          d.ansLast  = link.rspLast;
          if (link.rspLast) begin
            d.done = 1'b1;
            d.st   = M_LOAD;
            d.len  = 8'h00;
          end
        end else if (!q.heard && q.tmr == TW'(RETRY_CYCLES - 1)) begin
          if (q.tries >= 4'(TRIES)) begin
            d.noAnswer = 1'b1;
            d.st       = M_LOAD;
            d.len      = 8'h00;
          end else begin
            d.st  = M_SEND;
            d.idx = 8'h00;
          end
        end
      end
      default: begin
        d.st = M_LOAD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= M_LOAD;
    end else begin
      q <= d;
    end
  end

  // buffer is kept untouched through retries so the resend is identical
  always_ff @(posedge clk) begin
    if (bufWe) begin
      reqBuf[q.len] <= cmdData;
    end
  end

  assign cmdReady      = (q.st == M_LOAD);
  assign link.reqValid = q.reqValid;
  assign link.reqData  = q.reqData;
  assign link.reqLast  = q.reqLast;
  assign ansValid      = q.ansValid;
  assign ansData       = q.ansData;
  assign ansLast       = q.ansLast;
  assign done          = q.done;
  assign noAnswer      = q.noAnswer;
  assign refused       = q.refused;

endmodule

// ### mbs_link_asserts.sv
/*
  Link checker: watches the byte stream between master end and slave end.
  Assumes one clock for both ends and the slave's response count handed in.
*/
`timescale 1ns/1ps
module mbs_link_asserts #(
  parameter int unsigned RESP_CYCLES = mbs_pkg::RESP_CYC,
  parameter logic [7:0]  SLAVE_ADDR  = 8'h01
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reqValid,
  input wire logic [7:0] reqData,
  input wire logic       reqLast,
  input wire logic       rspValid,
  input wire logic [7:0] rspData,
  input wire logic       rspLast,
  input wire logic       lineOn
);
  logic [31:0] gapQ;      // cycles since the last request end
  logic        answeredQ; // an answer already went out for that request

  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // saturate so a long idle spell never wraps into a false early answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gapQ      <= 32'h0000_0000;
      answeredQ <= 1'b0;
    end else begin
      if (reqLast) gapQ <= 32'h0000_0000;
      else if (gapQ != 32'hffff_ffff) gapQ <= gapQ + 32'h0000_0001;
      if (reqLast) answeredQ <= 1'b0;
      else if (rspLast) answeredQ <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rsp_delay: assert property ($rose(rspValid) |-> gapQ >= 32'(RESP_CYCLES))
    else $error("answer began too soon after the request");
  a_half_duplex: assert property (reqValid |-> !rspValid)
    else $error("answer overlaps a request");
  a_rsp_addr: assert property ($rose(rspValid) |-> rspData == SLAVE_ADDR)
    else $error("answer carries a foreign or broadcast address");
  a_one_answer: assert property ($rose(rspValid) |-> !answeredQ)
    else $error("second answer to one request");
  a_rsp_awake: assert property ($rose(rspValid) |-> lineOn)
    else $error("answer sent while line circuit off");
  a_wake_edge: assert property ($rose(lineOn) |-> $past(reqLast))
    else $error("line circuit woke without a frame end");
  a_last_valid: assert property (rspLast |-> rspValid)
    else $error("answer end without a byte");
  a_rsp_burst: assert property (rspValid && !rspLast |=> rspValid)
    else $error("gap inside an answer");
  a_req_last: assert property (reqLast |-> reqValid)
    else $error("request end without a byte");

  c_answer: cover property (rspLast);
  c_wake: cover property ($rose(lineOn));
  c_asleep_req: cover property (reqLast && !lineOn);
endmodule

// ### modbus_slave_request_handler_tb.sv
/*
  Testbench: master end and slave end joined by the link; drives the master's
  command side. Assumes short response and retry counts to keep the run brief.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module modbus_slave_request_handler_tb;
  logic        clk;
  logic        rst_n;
  logic        cmdValid;
  logic        cmdLast;
  logic        lowPower;
  logic [7:0]  cmdData;
  logic [7:0]  appAddr;
  logic [15:0] appData;
  logic        cmdReady, ansValid, ansLast, done, noAnswer, refused, wrPulse;
  logic [7:0]  ansData;
  logic [2:0]  st;
  logic [7:0]  ans[$];
  logic [7:0]  mon[$];
  logic [7:0]  rq[$];
  int          error_cnt;
  int          checks_done;
  int          wrCnt;

  // ----------------------------------------------------------------
  // the two ends, the link and its checker
  // ----------------------------------------------------------------
  mbs_link_if mbs_link_if_i (.clk(clk));
  mbs_slave #(.RESP_CYCLES(20)) mbs_slave_i (.clk(clk), .rst_n(rst_n), .link(mbs_link_if_i),
    .lowPower(lowPower), .appAddr(appAddr), .appData(appData), .wrPulse(wrPulse));
  mbs_master #(.RETRY_CYCLES(400)) mbs_master_i (.clk(clk), .rst_n(rst_n),
    .link(mbs_link_if_i), .cmdValid(cmdValid), .cmdData(cmdData), .cmdLast(cmdLast),
    .cmdReady(cmdReady), .ansValid(ansValid), .ansData(ansData), .ansLast(ansLast),
    .done(done), .noAnswer(noAnswer), .refused(refused));
  mbs_link_asserts #(.RESP_CYCLES(20)) mbs_link_asserts_i (.clk(clk), .rst_n(rst_n),
    .reqValid(mbs_link_if_i.reqValid), .reqData(mbs_link_if_i.reqData),
    .reqLast(mbs_link_if_i.reqLast), .rspValid(mbs_link_if_i.rspValid),
    .rspData(mbs_link_if_i.rspData), .rspLast(mbs_link_if_i.rspLast),
    .lineOn(mbs_link_if_i.lineOn));

  // ----------------------------------------------------------------
  // clock, monitors, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // record link bytes so a retry can be compared with its original
  always @(posedge clk) begin
    if (mbs_link_if_i.reqValid === 1'b1) mon.push_back(mbs_link_if_i.reqData);
    if (wrPulse === 1'b1) wrCnt++;
  end
  // the whole run needs some 3100 cycles, retries included
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // send one request, then gather the answer until the master reports an outcome
  task automatic xfer(input logic [7:0] r[$]);
    int i;
    i = 0;
    ans.delete();
    while (i < r.size()) begin
      cmdValid <= 1'b1;
      cmdData  <= r[i];
      cmdLast  <= (i == r.size() - 1);
      @(posedge clk);
      if (cmdReady === 1'b1) i++;
    end
    cmdValid <= 1'b0;
    cmdLast  <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (ansValid === 1'b1) ans.push_back(ansData);
      st = {done, noAnswer, refused};
      if (st !== 3'b000) break;
    end
  endtask
  task automatic expect_ans(input logic [7:0] e[$]);
    `CHK("answer length", e.size(), ans.size())
    foreach (e[k]) if (k < ans.size()) `CHK("answer byte", e[k], ans[k])
  endtask
  // app port is registered, so give it two edges
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    appAddr <= a;
    repeat (2) @(posedge clk);
    `CHK("register", e, appData)
  endtask
  task automatic summarize();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdLast = 1'b0;
    cmdData = 8'h00;
    lowPower = 1'b0;
    appAddr = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    wrCnt = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer('{8'h01, 8'h06, 8'h00, 8'h05, 8'hbe, 8'hef});
    expect_ans('{8'h01, 8'h06, 8'h00, 8'h05, 8'hbe, 8'hef});
    `CHK("single write count", 1, wrCnt)
    chk_reg(8'h05, 16'hbeef);
    for (logic [7:0] c = 8'h03; c <= 8'h04; c++) begin
      xfer('{8'h01, c, 8'h00, 8'h05, 8'h00, 8'h01});
      expect_ans('{8'h01, c, 8'h02, 8'hbe, 8'hef});
    end
    // largest multi write, then the largest read over it
    rq = '{8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 8'h78, 8'hf0};
    for (int k = 0; k < 240; k++) rq.push_back(8'(k));
    wrCnt = 0;
    xfer(rq);
    expect_ans(rq[0:5]);
    `CHK("multi write count", 120, wrCnt)
    xfer('{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h7d});
    `CHK("read length", 253, ans.size())
    `CHK("byte count", 8'hfa, ans[2])
    for (int k = 0; k < 240; k++) `CHK("read data", 8'(k), ans[3+k])
    // counts one past each limit and an unknown code, then diagnostics and a good read/write
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7e});
    expect_ans('{8'h01, 8'h83, 8'h03});
    xfer('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h79, 8'hf2});
    expect_ans('{8'h01, 8'h90, 8'h03});
    xfer('{8'h01, 8'h17, 8'h00, 8'h20, 8'h00, 8'h77, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02,
           8'h00, 8'h00});
    expect_ans('{8'h01, 8'h97, 8'h03});
    xfer('{8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00});
    expect_ans('{8'h01, 8'h85, 8'h01});
    xfer('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
    expect_ans('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
    xfer('{8'h01, 8'h08, 8'h00, 8'h02, 8'h00, 8'h00});
    expect_ans('{8'h01, 8'h08, 8'h00, 8'h02, 8'h00, 8'h04});
    xfer('{8'h01, 8'h17, 8'h00, 8'h20, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02,
           8'h5a, 8'h5a});
    expect_ans('{8'h01, 8'h17, 8'h02, 8'h5a, 8'h5a});
    // broadcasts: executed silently, illegal code held back
    xfer('{8'h00, 8'h06, 8'h00, 8'h07, 8'h11, 8'h11});
    `CHK("broadcast outcome", 3'b100, st)
    `CHK("broadcast answer", 0, ans.size())
    xfer('{8'h00, 8'h10, 8'h00, 8'h08, 8'h00, 8'h01, 8'h02, 8'h22, 8'h22});
    repeat (20) @(posedge clk);
    chk_reg(8'h07, 16'h1111);
    chk_reg(8'h08, 16'h2222);
    xfer('{8'h00, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01});
    `CHK("illegal broadcast", 3'b001, st)
    // no slave at address 02: each try times out, then the master gives up
    mon.delete();
    xfer('{8'h02, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01});
    `CHK("no answer", 3'b010, st)
    `CHK("tries sent", 18, mon.size())
    // low power: first frame only wakes, the retry is answered
    lowPower <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("line off", 1'b0, mbs_link_if_i.lineOn)
    mon.delete();
    rq = '{8'h01, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
    xfer(rq);
    expect_ans('{8'h01, 8'h03, 8'h02, 8'hbe, 8'hef});
    `CHK("frames sent", 12, mon.size())
    for (int k = 0; k < 12; k++) `CHK("sent byte", rq[k%6], mon[k])
    repeat (4) @(posedge clk);
    `CHK("line off again", 1'b0, mbs_link_if_i.lineOn)
    summarize();
  end
endmodule
